// ---- shared/ipen_pkg.sv ----
// Package for the inter-partition event notifier: sizes, event codes, carriers.
// Assumes a single 250 MHz core clock and synchronous event inputs.
package ipen_pkg;
  localparam int NUM_PORTS = 8;
  localparam int NUM_PARTS = 4;
  localparam int NUM_SRC   = 8;
  localparam int MSG_W     = 32;
  localparam int PART_W    = 2;

  // Event source codes, one status bit per code
  localparam int SRC_LINK_UP   = 0;
  localparam int SRC_LINK_DOWN = 1;
  localparam int SRC_AER       = 2;
  localparam int SRC_FUND_RST  = 3;
  localparam int SRC_HOT_RST   = 4;
  localparam int SRC_FO_START  = 5;
  localparam int SRC_FO_DONE   = 6;
  localparam int SRC_GSIG      = 7;

  localparam logic [NUM_SRC-1:0]   STAT_RESET = 8'h00;
  localparam logic [MSG_W-1:0]     MSG_RESET  = 32'h0000_0000;
  localparam logic [NUM_PORTS-1:0] PORT_NONE  = 8'h00;

  // Per-port operating mode
  typedef enum logic [1:0] {
    IPEN_MODE_DISABLED   = 2'h0,
    IPEN_MODE_UNATTACHED = 2'h1,
    IPEN_MODE_UPSTREAM   = 2'h2,
    IPEN_MODE_OTHER      = 2'h3
  } ipen_mode_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] dl_up;
    logic [NUM_PORTS-1:0] aer_err;
    logic [NUM_PARTS-1:0] fund_rst;
    logic [NUM_PARTS-1:0] hot_rst;
    logic                 fo_start;
    logic                 fo_done;
  } ipen_hw_ev_t;

  typedef struct packed {
    logic              wr;
    logic [MSG_W-1:0]  data;
  } ipen_gsig_t;
endpackage

// ---- logic/ipen_part_stat.sv ----
// Per-partition sticky status and interrupt request for one receiving partition.
// Assumes raised events are one-cycle pulses already filtered by routing.
`timescale 1ns/1ps
module ipen_part_stat (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [ipen_pkg::NUM_SRC-1:0]  raise_i,
  input  wire logic [ipen_pkg::NUM_SRC-1:0]  clear_i,
  input  wire logic                          attached_i,
  output logic      [ipen_pkg::NUM_SRC-1:0]  status_o,
  output logic                               irq_o
);
  logic [ipen_pkg::NUM_SRC-1:0] status;
  wire  [ipen_pkg::NUM_SRC-1:0] next_status;

  // Set wins over a clear in the same cycle; detached partitions hold nothing
  assign next_status = attached_i ? ((status & ~clear_i) | raise_i) : ipen_pkg::STAT_RESET;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status <= ipen_pkg::STAT_RESET;
      irq_o  <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq_o  <= |next_status;
    end
  end

  assign status_o = status;
endmodule

// ---- logic/ipen_top.sv ----
// Inter-partition event notifier: detects switch events and routes them to partitions.
// Assumes synchronous inputs, configuration held stable by the management logic.
`timescale 1ns/1ps
module ipen_top (
  input  wire logic                                             clk_i,
  input  wire logic                                             rst_n_i,
  input  wire ipen_pkg::ipen_hw_ev_t                            hw_ev_i,
  input  wire ipen_pkg::ipen_gsig_t [ipen_pkg::NUM_PARTS-1:0]   gsig_i,
  input  wire logic [ipen_pkg::NUM_SRC-1:0][ipen_pkg::NUM_PARTS-1:0] route_i,
  input  wire ipen_pkg::ipen_mode_t [ipen_pkg::NUM_PORTS-1:0]   port_mode_i,
  input  wire logic [ipen_pkg::NUM_PORTS-1:0][ipen_pkg::PART_W-1:0] port_part_i,
  input  wire logic [ipen_pkg::NUM_PARTS-1:0][ipen_pkg::NUM_SRC-1:0] clear_i,
  output logic [ipen_pkg::NUM_PARTS-1:0][ipen_pkg::NUM_SRC-1:0] status_o,
  output logic [ipen_pkg::NUM_PARTS-1:0]                        irq_o,
  output logic [ipen_pkg::MSG_W-1:0]                            msg_o,
  output logic [ipen_pkg::PART_W-1:0]                           msg_src_o
);
  localparam int NP = ipen_pkg::NUM_PARTS;
  localparam int NQ = ipen_pkg::NUM_PORTS;
  localparam int NS = ipen_pkg::NUM_SRC;
  localparam int PW = ipen_pkg::PART_W;
  localparam int MW = ipen_pkg::MSG_W;

  // Link state at the previous edge. Reset clears it, so a link that is
  // already up when reset lifts is reported once as coming up.
  logic [NQ-1:0]          dl_up_q;
  logic [MW-1:0]          msg;
  logic [PW-1:0]          msg_src;

  // Per-port decode
  wire  [NQ-1:0]          port_disabled;
  wire  [NQ-1:0]          port_unattached;
  wire  [NQ-1:0]          port_member;
  wire  [NQ-1:0]          port_upstream;
  wire  [NQ-1:0]          up_edge;
  wire  [NQ-1:0]          down_edge;
  wire  [NQ-1:0]          aer_hit;

  // Per-source events, one wire each
  wire                    ev_link_up;
  wire                    ev_link_down;
  wire                    ev_aer;
  wire                    ev_fund_rst;
  wire                    ev_hot_rst;
  wire                    ev_fo_start;
  wire                    ev_fo_done;
  wire                    ev_gsig;
  wire  [NS-1:0]          event_now;

  // Per-partition decode
  wire  [NP-1:0]          part_attached;
  wire  [NP-1:0]          gsig_wr;
  wire  [NP-1:0]          gsig_lower;
  wire  [NP-1:0]          gsig_first;
  wire  [NP-1:0][NS-1:0]  route_mask;
  wire  [NP-1:0][NS-1:0]  raise;
  wire  [NP-1:0][NS-1:0]  status;
  wire  [NP-1:0]          irq;

  // Message pick
  wire  [NP-1:0][MW-1:0]  msg_term;
  wire  [NP-1:0][PW-1:0]  src_term;
  wire  [NP:0][MW-1:0]    msg_or;
  wire  [NP:0][PW-1:0]    src_or;
  wire  [MW-1:0]          next_msg;
  wire  [PW-1:0]          next_msg_src;

  genvar gq;
  genvar gp;
  genvar gk;
  genvar gs;

  // Port classification, link edges and error levels
  generate
    for (gq = 0; gq < NQ; gq++)
    begin : g_port
      assign port_disabled[gq]   = (port_mode_i[gq] == ipen_pkg::IPEN_MODE_DISABLED);
      assign port_unattached[gq] = (port_mode_i[gq] == ipen_pkg::IPEN_MODE_UNATTACHED);
      assign port_upstream[gq]   = (port_mode_i[gq] == ipen_pkg::IPEN_MODE_UPSTREAM);
      // Disabled and unattached ports belong to no partition
      assign port_member[gq]     = !port_disabled[gq] && !port_unattached[gq];

      assign up_edge[gq]   = hw_ev_i.dl_up[gq] && !dl_up_q[gq] && port_member[gq];
      assign down_edge[gq] = !hw_ev_i.dl_up[gq] && dl_up_q[gq] && port_member[gq];
      assign aer_hit[gq]   = hw_ev_i.aer_err[gq] && port_member[gq];
    end
  endgenerate

  // Each source collapses to one bit; the receiver learns the kind, not the port
  assign ev_link_up   = |up_edge;
  assign ev_link_down = |down_edge;
  assign ev_aer       = |aer_hit;
  assign ev_fund_rst  = |hw_ev_i.fund_rst;
  assign ev_hot_rst   = |hw_ev_i.hot_rst;
  assign ev_fo_start  = hw_ev_i.fo_start;
  assign ev_fo_done   = hw_ev_i.fo_done;
  assign ev_gsig      = |gsig_wr;

  assign event_now[ipen_pkg::SRC_LINK_UP]   = ev_link_up;
  assign event_now[ipen_pkg::SRC_LINK_DOWN] = ev_link_down;
  assign event_now[ipen_pkg::SRC_AER]       = ev_aer;
  assign event_now[ipen_pkg::SRC_FUND_RST]  = ev_fund_rst;
  assign event_now[ipen_pkg::SRC_HOT_RST]   = ev_hot_rst;
  assign event_now[ipen_pkg::SRC_FO_START]  = ev_fo_start;
  assign event_now[ipen_pkg::SRC_FO_DONE]   = ev_fo_done;
  assign event_now[ipen_pkg::SRC_GSIG]      = ev_gsig;

  // Per receiving partition: attachment, routing and sticky status
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_part
      wire [NQ-1:0] is_up;

      for (gk = 0; gk < NQ; gk++)
      begin : g_up
        assign is_up[gk] = port_upstream[gk] && (port_part_i[gk] == PW'(gp));
      end

      // Only an upstream port can carry the interrupt, so a partition without
      // one is never notified, whatever the routing says
      assign part_attached[gp] = |is_up;
      assign gsig_wr[gp]       = gsig_i[gp].wr && part_attached[gp];

      for (gs = 0; gs < NS; gs++)
      begin : g_src
        assign route_mask[gp][gs] = route_i[gs][gp];
      end

      assign raise[gp] = event_now & route_mask[gp];

      ipen_part_stat u_stat (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .raise_i    (raise[gp]),
        .clear_i    (clear_i[gp]),
        .attached_i (part_attached[gp]),
        .status_o   (status[gp]),
        .irq_o      (irq[gp])
      );
    end
  endgenerate

  // Lowest partition wins when two signal in the same cycle; the others'
  // events still latch, only their message words are lost
  assign gsig_lower[0] = 1'b0;

  generate
    for (gp = 1; gp < NP; gp++)
    begin : g_prio
      assign gsig_lower[gp] = gsig_lower[gp-1] || gsig_wr[gp-1];
    end
  endgenerate

  assign gsig_first = gsig_wr & ~gsig_lower;

  // One-hot and-or pick, so no priority chain sits on the data path
  assign msg_or[0] = '0;
  assign src_or[0] = '0;

  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pick
      assign msg_term[gp] = gsig_first[gp] ? gsig_i[gp].data : '0;
      assign src_term[gp] = gsig_first[gp] ? PW'(gp) : '0;
      assign msg_or[gp+1] = msg_or[gp] | msg_term[gp];
      assign src_or[gp+1] = src_or[gp] | src_term[gp];
    end
  endgenerate

  // Nothing written this cycle: the last message stands
  assign next_msg     = ev_gsig ? msg_or[NP] : msg;
  assign next_msg_src = ev_gsig ? src_or[NP] : msg_src;

  // Link history for the edge detectors
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dl_up_q <= ipen_pkg::PORT_NONE;
    end
    else
    begin
      dl_up_q <= hw_ev_i.dl_up;
    end
  end

  // Message store; the output copy keeps msg_o straight off a flip-flop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      msg       <= ipen_pkg::MSG_RESET;
      msg_src   <= '0;
      msg_o     <= ipen_pkg::MSG_RESET;
      msg_src_o <= '0;
    end
    else
    begin
      msg       <= next_msg;
      msg_src   <= next_msg_src;
      msg_o     <= next_msg;
      msg_src_o <= next_msg_src;
    end
  end

  // Both come straight from the leaf flip-flops
  assign status_o = status;
  assign irq_o    = irq;
endmodule

// ---- bench/ipen_sva.sv ----
// Checker for the notifier top: event latching, hold, interrupt level and message.
// Sees only top ports; configuration is taken as stable while events fire.
`timescale 1ns/1ps
module ipen_sva (
  input wire logic                        clk_i,
  input wire logic                        rst_n_i,
  input wire ipen_pkg::ipen_hw_ev_t       hw_ev_i,
  input wire ipen_pkg::ipen_gsig_t [3:0]  gsig_i,
  input wire logic [7:0][3:0]             route_i,
  input wire ipen_pkg::ipen_mode_t [7:0]  port_mode_i,
  input wire logic [7:0][1:0]             port_part_i,
  input wire logic [3:0][7:0]             clear_i,
  input wire logic [3:0][7:0]             status_o,
  input wire logic [3:0]                  irq_o,
  input wire logic [31:0]                 msg_o,
  input wire logic [1:0]                  msg_src_o
);
  logic [3:0] up, wr, any;
  logic [7:0] att;
  always_comb
  begin
    up = '0;
    for (int i = 0; i < 8; i++)
    begin
      att[i] = port_mode_i[i][1];
      if (port_mode_i[i] == ipen_pkg::IPEN_MODE_UPSTREAM) up[port_part_i[i]] = 1'b1;
    end
    for (int p = 0; p < 4; p++)
    begin
      wr[p] = gsig_i[p].wr;
      any[p] = |status_o[p];
    end
  end
  function automatic logic [3:0] col(input logic [3:0][7:0] st, input int s);
    for (int p = 0; p < 4; p++) col[p] = st[p][s];
  endfunction
  // Only partitions with an upstream port can be owed a bit
  property set_p(ev, s);
    ev |=> (col(status_o, s) & $past(route_i[s] & up)) == $past(route_i[s] & up);
  endproperty
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_link_up_set: assert property (set_p(|(hw_ev_i.dl_up & ~$past(hw_ev_i.dl_up) & att), 0))
    else $error("link up event not latched");
  chk_aer_set: assert property (set_p(|(hw_ev_i.aer_err & att), 2))
    else $error("error event not latched");
  chk_fund_set: assert property (set_p(|hw_ev_i.fund_rst, 3))
    else $error("fundamental reset event not latched");
  chk_fo_start_set: assert property (set_p(hw_ev_i.fo_start, 5))
    else $error("failover start event not latched");
  chk_gsig_set: assert property (set_p(|(wr & up), 7))
    else $error("global signal event not latched");
  chk_irq_level: assert property (irq_o == any)
    else $error("interrupt does not follow status");
  chk_sticky_hold: assert property (($past(status_o & ~clear_i) & ~status_o) == '0)
    else $error("status bit dropped without clear");
  chk_msg_load: assert property (wr[1] && up[1] && !(wr[0] && up[0])
    |=> msg_o == $past(gsig_i[1].data) && msg_src_o == 2'h1) else $error("message not loaded");
endmodule
bind ipen_top ipen_sva u_sva (.clk_i, .rst_n_i, .hw_ev_i, .gsig_i, .route_i, .port_mode_i,
  .port_part_i, .clear_i, .status_o, .irq_o, .msg_o, .msg_src_o);

// ---- bench/ipen_rc_model.sv ----
// Model of each partition's root complex: answers an interrupt after a latency.
// Clears only the bits seen, so an event landing meanwhile stays pending.
`timescale 1ns/1ps
module ipen_rc_model (
  input  wire logic            clk_i,
  input  wire logic            en_i,
  input  wire logic [3:0]      lat_i,
  input  wire logic [3:0]      irq_i,
  input  wire logic [3:0][7:0] status_i,
  output logic      [3:0][7:0] clear_o
);
  int wait_cnt [4];
  initial clear_o = '0;
  always @(negedge clk_i)
  begin
    clear_o = '0;
    for (int p = 0; p < 4; p++)
    begin
      wait_cnt[p] = (en_i && irq_i[p]) ? wait_cnt[p] + 1 : 0;
      if (wait_cnt[p] > lat_i) clear_o[p] = status_i[p];
    end
  end
endmodule

// ---- bench/ipen_top_test.sv ----
// Testbench: fires every event source under corner and random routing.
// Assumes the root complex model is the only party that clears status.
`timescale 1ns/1ps
module ipen_top_test;
  localparam logic [3:0] UP = 4'h7;
  logic clk_i, rst_n_i, en;
  ipen_pkg::ipen_hw_ev_t hw;
  ipen_pkg::ipen_gsig_t [3:0] gs;
  ipen_pkg::ipen_mode_t [7:0] mode;
  logic [7:0][3:0] route;
  logic [7:0][1:0] part;
  logic [3:0][7:0] clr, st;
  logic [3:0] irq, lat;
  logic [31:0] msg, rnd;
  logic [1:0] src;
  int failures, check_count, seed = 32'h0000_4384;
  ipen_top u_dut (.clk_i, .rst_n_i, .hw_ev_i(hw), .gsig_i(gs), .route_i(route), .port_mode_i(mode),
    .port_part_i(part), .clear_i(clr), .status_o(st), .irq_o(irq), .msg_o(msg), .msg_src_o(src));
  ipen_rc_model u_rc (.clk_i, .en_i(en), .lat_i(lat), .irq_i(irq), .status_i(st), .clear_o(clr));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] exp_st(input int s, input logic [3:0] m);
    exp_st = '0;
    for (int p = 0; p < 4; p++) exp_st[p*8+s] = m[p] & UP[p];
  endfunction
  task automatic fire(input int s, input logic [3:0] m);
    route = '0;
    route[s] = m;
    rnd = $random(seed);
    @(negedge clk_i);
    case (s)
      0: hw.dl_up[4] = 1'b1;
      1: hw.dl_up[4] = 1'b0;
      2: hw.aer_err[4] = 1'b1;
      3: hw.fund_rst[rnd[1:0]] = 1'b1;
      4: hw.hot_rst[rnd[1:0]] = 1'b1;
      5: hw.fo_start = 1'b1;
      6: hw.fo_done = 1'b1;
      default: gs[1] = '{wr: 1'b1, data: rnd};
    endcase
    @(negedge clk_i);
    hw = '{dl_up: hw.dl_up, default: '0};
    gs = '0;
    chk("status", exp_st(s, m), st);
    chk("irq", {28'h0, m & UP}, irq);
    if (s == 7) chk("msg", rnd, msg);
    if (s == 7) chk("msg_src", 32'h0000_0001, {30'h0, src});
    repeat (5) @(negedge clk_i);
    chk("status_hold", exp_st(s, m), st);
    lat = rnd[7:4];
    en = 1'b1;
    for (int i = 0; i < 40 && st !== '0; i++) @(negedge clk_i);
    en = 1'b0;
    chk("status_clear", 32'h0, st);
    $display("test source %0d done", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    en = 1'b0;
    lat = 4'h0;
    hw = '0;
    gs = '0;
    route = '0;
    part = 16'h04E4;
    for (int i = 0; i < 8; i++) mode[i] = ipen_pkg::ipen_mode_t'(2'(16'h072A >> (2 * i)));
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk("reset", 32'h0, st | msg);
    chk("reset_irq", 32'h0, {28'h0, irq});
    $display("test reset done");
    for (int r = 0; r < 2; r++)
      for (int s = 0; s < 8; s++) fire(s, r == 0 ? 4'hF : 4'h8 | 4'($random(seed)));
    route = '1;
    hw.aer_err[5] = 1'b1;
    hw.dl_up[3] = 1'b1;
    gs[3] = '{wr: 1'b1, data: ~rnd};
    @(negedge clk_i);
    hw = '0;
    gs = '0;
    chk("refused", 32'h0, st);
    chk("msg_keep", rnd, msg);
    $display("test refused done");
    wrap_up();
  end
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
